// ==== common/ags_pkg.sv ====
// constants, register map and field layout of the analog gain/offset scaler
// assumes a 40 MHz system clock and a plain strobe register port
package ags_pkg;
	localparam int                 ADDR_W        = 5;
	localparam int                 DATA_W        = 32;
	localparam int                 INT_W         = 10;
	localparam int                 GAIN_W        = 11;
	localparam int                 OFFS_W        = 15;
	localparam int                 RES_W         = 16;
	localparam int                 SFB_N         = 10;
	localparam logic [INT_W-1:0]   INT_MAX       = 10'h3e8;
	localparam int                 INT_MAX_I     = 1000;
	localparam int                 GAIN_DIV      = 100;
	localparam logic signed [31:0] GAIN_MIN      = -32'sd1000;
	localparam logic signed [31:0] GAIN_MAX      = 32'sd1000;
	localparam logic signed [31:0] OFFS_MIN      = -32'sd10000;
	localparam logic signed [31:0] OFFS_MAX      = 32'sd10000;
	localparam logic [GAIN_W-1:0]  GAIN_RST      = 11'h064;
	localparam logic [OFFS_W-1:0]  OFFS_RST      = 15'h0000;
	localparam logic [SFB_N-1:0]   RETAIN_OK     = 10'h37f;
	localparam int                 RANDOM_IDX    = 7;
	localparam logic [ADDR_W-1:0]  A_GAIN        = 5'h00;
	localparam logic [ADDR_W-1:0]  A_OFFSET      = 5'h04;
	localparam logic [ADDR_W-1:0]  A_INV_MASK    = 5'h08;
	localparam logic [ADDR_W-1:0]  A_RETAIN      = 5'h0c;
	localparam logic [ADDR_W-1:0]  A_INTERNAL    = 5'h10;
	localparam logic [ADDR_W-1:0]  A_SCALED      = 5'h14;
	localparam logic [ADDR_W-1:0]  A_STATUS      = 5'h18;
	localparam int                 ST_SAT_BIT    = 0;
	localparam int                 ST_PFAIL_BIT  = 1;
endpackage

// ==== common/ags_scale_if.sv ====
// carrier between the register top and the scaling datapath
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ags_scale_if #(
	parameter int ADC_W = 12
);
	import ags_pkg::*;
	logic [ADC_W-1:0]         raw;
	logic signed [GAIN_W-1:0] gain;
	logic signed [OFFS_W-1:0] offset;
	logic [INT_W-1:0]         internal;
	logic                     saturated;
	logic signed [RES_W-1:0]  result;
	modport ctrl (output raw, output gain, output offset,
		input internal, input saturated, input result);
	modport core (input raw, input gain, input offset,
		output internal, output saturated, output result);
endinterface

// ==== rtl/ags_scaler_core.sv ====
// scaling datapath: converter code to internal value, then gain and offset
// assumes synchronised converter code and range-checked gain and offset
`timescale 1ns/1ps
module ags_scaler_core #(
	parameter int ADC_W   = 12,
	parameter int FS_CODE = 4000
) (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	ags_scale_if.core  sc
);
	import ags_pkg::*;

	localparam int PW = ADC_W + INT_W;

	logic [PW-1:0]            raw_scaled;
	logic [PW-1:0]            raw_quot;
	logic signed [21:0]       product;
	logic signed [21:0]       quot;
	logic signed [RES_W-1:0]  next_result;

	assign raw_scaled = PW'(sc.raw) * PW'(INT_MAX_I);
	assign raw_quot   = raw_scaled / PW'(FS_CODE);

	// linear map with saturation at full scale
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc.internal  <= '0;
			sc.saturated <= 1'b0;
		end else if (sc.raw >= ADC_W'(FS_CODE)) begin
			sc.internal  <= INT_MAX;
			sc.saturated <= sc.raw > ADC_W'(FS_CODE);
		end else begin
			sc.internal  <= raw_quot[INT_W-1:0];
			sc.saturated <= 1'b0;
		end
	end

	// gain in hundredths, fraction truncated toward zero, then offset
	assign product     = $signed({12'h000, sc.internal}) * 22'(sc.gain);
	assign quot        = product / 22'(GAIN_DIV);
	assign next_result = RES_W'(quot) + RES_W'(sc.offset);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc.result <= '0;
		end else begin
			sc.result <= next_result;
		end
	end
endmodule // ags_scaler_core

// ==== rtl/ags_analog_scaler.sv ====
// top of the analog input scaler with special-function input conditioning
// assumes pins asynchronous to CLK_SYS_I and a one-cycle-latency register port
//
// Overview of operation
// - input 0..10 V maps linearly onto internal value 0..1000
// - above full scale the internal value stays at 1000
// - scaled value is internal value times gain, plus offset
// - gain is signed hundredths, limited to -10.00..+10.00
// - offset is signed integer -10000..+10000, added after the product
// - each special-function input has its own selectable inversion
// - retain selectable for timing blocks, never for the random generator
// - retained blocks keep state across power loss, others restart
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module ags_analog_scaler #(
	parameter int ADC_W   = 12,
	parameter int FS_CODE = 4000
) (
	input  wire logic                         CLK_SYS_I,
	input  wire logic                         SYS_RST_I,
	input  wire logic [ADC_W-1:0]             ANALOG_VOLTAGE_INPUT_I,
	input  wire logic [ags_pkg::SFB_N-1:0]    SFB_IN_I,
	input  wire logic                         POWER_FAIL_I,
	input  wire logic [ags_pkg::ADDR_W-1:0]   REG_ADDR_I,
	input  wire logic [ags_pkg::DATA_W-1:0]   REG_WDATA_I,
	input  wire logic                         REG_WR_I,
	input  wire logic                         REG_RD_I,
	output logic      [ags_pkg::DATA_W-1:0]   REG_RDATA_O,
	output logic signed [ags_pkg::RES_W-1:0]  SCALED_ANALOG_VALUE_O,
	output logic      [ags_pkg::SFB_N-1:0]    SFB_IN_O,
	output logic      [ags_pkg::SFB_N-1:0]    SFB_RETAIN_O,
	output logic      [ags_pkg::SFB_N-1:0]    SFB_RESTART_O
);
	import ags_pkg::*;

	ags_scale_if #(.ADC_W(ADC_W)) sc ();

	logic [ADC_W-1:0]         raw_s1;
	logic [ADC_W-1:0]         raw_s2;
	logic [ADC_W-1:0]         raw_s3;
	logic [ADC_W-1:0]         raw_hld;
	logic [SFB_N-1:0]         in_s1;
	logic [SFB_N-1:0]         in_s2;
	logic                     pf_s1;
	logic                     pf_s2;
	logic                     pf_d;
	logic signed [GAIN_W-1:0] gain;
	logic signed [OFFS_W-1:0] offset;
	logic [SFB_N-1:0]         inv_mask;
	logic [SFB_N-1:0]         retain;
	logic signed [31:0]       wdata_s;
	logic [DATA_W-1:0]        next_rdata;

	ags_scaler_core #(
		.ADC_W   (ADC_W),
		.FS_CODE (FS_CODE)
	) u_core (
		.clk_i (CLK_SYS_I),
		.rst_i (SYS_RST_I),
		.sc    (sc.core)
	);

	assign sc.raw    = raw_hld;
	assign sc.gain   = gain;
	assign sc.offset = offset;
	assign wdata_s   = $signed(REG_WDATA_I);

	// two-stage synchronisers for the pins
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			raw_s1 <= '0;
			raw_s2 <= '0;
		end else begin
			raw_s1 <= ANALOG_VOLTAGE_INPUT_I;
			raw_s2 <= raw_s1;
		end
	end

	// converter bits may settle apart: a code is taken only once seen twice in a row
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			raw_s3  <= '0;
			raw_hld <= '0;
		end else begin
			raw_s3 <= raw_s2;
			if (raw_s2 == raw_s3) begin
				raw_hld <= raw_s3;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			in_s1 <= '0;
			in_s2 <= '0;
		end else begin
			in_s1 <= SFB_IN_I;
			in_s2 <= in_s1;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			pf_s1 <= 1'b0;
			pf_s2 <= 1'b0;
			pf_d  <= 1'b0;
		end else begin
			pf_s1 <= POWER_FAIL_I;
			pf_s2 <= pf_s1;
			pf_d  <= pf_s2;
		end
	end

	// gain and offset writes are clamped into their accepted range
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			gain <= GAIN_RST;
		end else if (REG_WR_I && REG_ADDR_I == A_GAIN) begin
			if (wdata_s < GAIN_MIN) begin
				gain <= GAIN_W'(GAIN_MIN);
			end else if (wdata_s > GAIN_MAX) begin
				gain <= GAIN_W'(GAIN_MAX);
			end else begin
				gain <= GAIN_W'(wdata_s);
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			offset <= OFFS_RST;
		end else if (REG_WR_I && REG_ADDR_I == A_OFFSET) begin
			if (wdata_s < OFFS_MIN) begin
				offset <= OFFS_W'(OFFS_MIN);
			end else if (wdata_s > OFFS_MAX) begin
				offset <= OFFS_W'(OFFS_MAX);
			end else begin
				offset <= OFFS_W'(wdata_s);
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			inv_mask <= '0;
		end else if (REG_WR_I && REG_ADDR_I == A_INV_MASK) begin
			inv_mask <= REG_WDATA_I[SFB_N-1:0];
		end
	end

	// random generator bit cannot be set
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			retain <= '0;
		end else if (REG_WR_I && REG_ADDR_I == A_RETAIN) begin
			retain <= REG_WDATA_I[SFB_N-1:0] & RETAIN_OK;
		end
	end

	// per-input inversion
	genvar gi;
	generate
		for (gi = 0; gi < SFB_N; gi++) begin : g_inv
			always_ff @(posedge CLK_SYS_I) begin
				if (SYS_RST_I) begin
					SFB_IN_O[gi] <= 1'b0;
				end else begin
					SFB_IN_O[gi] <= in_s2[gi] ^ inv_mask[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			SFB_RETAIN_O <= '0;
		end else begin
			SFB_RETAIN_O <= retain;
		end
	end

	// on power return, only blocks without retain are restarted
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			SFB_RESTART_O <= '0;
		end else if (pf_d && !pf_s2) begin
			SFB_RESTART_O <= ~retain;
		end else begin
			SFB_RESTART_O <= '0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			SCALED_ANALOG_VALUE_O <= '0;
		end else begin
			SCALED_ANALOG_VALUE_O <= sc.result;
		end
	end

	// read mux, unmapped reads answer zero
	always_comb begin
		next_rdata = '0;
		case (REG_ADDR_I)
			A_GAIN:     next_rdata = DATA_W'(signed'(gain));
			A_OFFSET:   next_rdata = DATA_W'(signed'(offset));
			A_INV_MASK: next_rdata = DATA_W'(inv_mask);
			A_RETAIN:   next_rdata = DATA_W'(retain);
			A_INTERNAL: next_rdata = DATA_W'(sc.internal);
			A_SCALED:   next_rdata = DATA_W'(signed'(sc.result));
			A_STATUS: begin
				next_rdata[ST_SAT_BIT]   = sc.saturated;
				next_rdata[ST_PFAIL_BIT] = pf_s2;
			end
			default:    next_rdata = '0;
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O <= '0;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= next_rdata;
		end else begin
			REG_RDATA_O <= '0;
		end
	end
endmodule // ags_analog_scaler

// ==== verif/ags_checker.sv ====
// assertions on the scaler top ports
// assumes binding into ags_analog_scaler
`timescale 1ns/1ps
module ags_checker
	import ags_pkg::*;
#(
	parameter int ADC_W   = 12,
	parameter int FS_CODE = 4000
) (
	input wire logic              CLK_SYS_I,
	input wire logic              SYS_RST_I,
	input wire logic [ADC_W-1:0]  ANALOG_VOLTAGE_INPUT_I,
	input wire logic [SFB_N-1:0]  SFB_IN_I,
	input wire logic              POWER_FAIL_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic              REG_RD_I,
	input wire logic [DATA_W-1:0] REG_RDATA_O,
	input wire logic [SFB_N-1:0]  SFB_IN_O,
	input wire logic [SFB_N-1:0]  SFB_RETAIN_O,
	input wire logic [SFB_N-1:0]  SFB_RESTART_O
);
	logic [ADC_W-1:0] prev;
	logic [2:0]       stab;
	// counts cycles of a steady converter code
	always_ff @(posedge CLK_SYS_I) begin
		prev <= ANALOG_VOLTAGE_INPUT_I;
		stab <= (SYS_RST_I || prev != ANALOG_VOLTAGE_INPUT_I) ? 3'h0 : stab + {2'h0, stab != 3'h7};
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	property p_lin;
		stab == 3'h7 && $past(REG_RD_I && REG_ADDR_I == A_INTERNAL) |-> REG_RDATA_O ==
			(ANALOG_VOLTAGE_INPUT_I > FS_CODE ? 1000 : ANALOG_VOLTAGE_INPUT_I * 1000 / FS_CODE);
	endproperty
	a_lin: assert property (p_lin) else $error("internal value off");
	property p_gain;
		$past(REG_RD_I && REG_ADDR_I == A_GAIN) |->
			$signed(REG_RDATA_O) >= GAIN_MIN && $signed(REG_RDATA_O) <= GAIN_MAX;
	endproperty
	a_gain: assert property (p_gain) else $error("gain out of range");
	property p_offs;
		$past(REG_RD_I && REG_ADDR_I == A_OFFSET) |->
			$signed(REG_RDATA_O) >= OFFS_MIN && $signed(REG_RDATA_O) <= OFFS_MAX;
	endproperty
	a_offs: assert property (p_offs) else $error("offset out of range");
	property p_retrd;
		$past(REG_RD_I && REG_ADDR_I == A_RETAIN) |-> !REG_RDATA_O[RANDOM_IDX];
	endproperty
	a_retrd: assert property (p_retrd) else $error("random block retained");
	property p_keep;
		(SFB_RESTART_O & SFB_RETAIN_O) == '0;
	endproperty
	a_keep: assert property (p_keep) else $error("retained block restarted");
	property p_pulse;
		|SFB_RESTART_O |=> SFB_RESTART_O == '0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("restart too long");
	property p_pwr;
		$fell(POWER_FAIL_I) |-> ##[2:5] SFB_RESTART_O[RANDOM_IDX];
	endproperty
	a_pwr: assert property (p_pwr) else $error("no restart");
	property p_inv;
		SFB_IN_I != $past(SFB_IN_I) |-> ##3 SFB_IN_O != $past(SFB_IN_O);
	endproperty
	a_inv: assert property (p_inv) else $error("input change lost");
endmodule // ags_checker

// ==== verif/ags_sensor_model.sv ====
// sensor and converter model: millivolts in, converter code out
// assumes FS_CODE at 10 V, clipping at the top code
`timescale 1ns/1ps
module ags_sensor_model #(
	parameter int ADC_W   = 12,
	parameter int FS_CODE = 4000
) (
	input  wire logic [15:0]      mv_i,
	output logic      [ADC_W-1:0] code_o
);
	int c;
	assign c = mv_i * FS_CODE / 10000;
	assign code_o = (c > 2 ** ADC_W - 1) ? '1 : c[ADC_W-1:0];
endmodule // ags_sensor_model

// ==== verif/tb.sv ====
// self-checking bench for the analog scaler
// assumes the sensor model on the converter pins
`timescale 1ns/1ps
module tb;
	import ags_pkg::*;
	logic                    clk = 0, rst = 1, pf = 0, wr = 0, rd = 0;
	logic [ADDR_W-1:0]       addr = '0;
	logic [DATA_W-1:0]       wd = '0;
	logic [SFB_N-1:0]        sfi = '0, acc;
	logic [15:0]             mv = '0;
	wire  [11:0]             code;
	wire  [DATA_W-1:0]       rdat;
	wire  signed [RES_W-1:0] sc;
	wire  [SFB_N-1:0]        sfo, ret, rs;
	int                      error_cnt = 0, total_checks = 0;
	int rows[16][4] = '{'{0, 10, -30, -30}, '{3000, 10, -30, 0}, '{10000, 10, -30, 70},
		'{0, 400, 1000, 1000}, '{6750, 400, 1000, 3700}, '{10000, 400, 1000, 5000},
		'{5000, 1, 0, 5}, '{10000, 1000, 0, 10000}, '{5000, 1, 5, 10}, '{10000, 100, -200, 800},
		'{10000, 1000, -10000, 0}, '{20, 1, 0, 0}, '{20, 1000, 0, 20}, '{20, -10, 0, 0},
		'{5000, -1, 0, -5}, '{12000, 100, 0, 1000}};
	initial forever #12.5 clk = ~clk;
	ags_sensor_model sen_u (.mv_i(mv), .code_o(code));
	ags_analog_scaler dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst), .ANALOG_VOLTAGE_INPUT_I(code),
		.SFB_IN_I(sfi), .POWER_FAIL_I(pf), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdat), .SCALED_ANALOG_VALUE_O(sc), .SFB_IN_O(sfo),
		.SFB_RETAIN_O(ret), .SFB_RESTART_O(rs));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(A_GAIN, 32'h64);
		rdc(A_OFFSET, 32'h0);
		foreach (rows[i]) begin
			@(posedge clk);
			mv <= 16'(rows[i][0]);
			wrr(A_GAIN, rows[i][1]);
			wrr(A_OFFSET, rows[i][2]);
			repeat (8) @(posedge clk);
			#1 chk(sc, rows[i][3]);
			rdc(A_SCALED, rows[i][3]);
		end
		rdc(A_INTERNAL, 1000);
		rdc(A_STATUS, 32'h1);
		wrr(A_GAIN, 2000);
		rdc(A_GAIN, 1000);
		wrr(A_GAIN, -2000);
		rdc(A_GAIN, -1000);
		wrr(A_OFFSET, -20000);
		rdc(A_OFFSET, -10000);
		rdc(5'h1c, 0);
		wrr(A_INV_MASK, 10'h2a5);
		@(posedge clk);
		sfi <= 10'h0f0;
		repeat (5) @(posedge clk);
		#1 chk(sfo, 10'h0f0 ^ 10'h2a5);
		wrr(A_RETAIN, 10'h3ff);
		rdc(A_RETAIN, RETAIN_OK);
		@(posedge clk);
		pf <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(A_STATUS, 32'h3);
		@(posedge clk);
		pf <= 1'b0;
		acc = '0;
		repeat (8) begin
			@(posedge clk);
			#1 acc |= rs;
		end
		chk(acc, 10'h080);
		chk(ret, RETAIN_OK);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(sc, 0);
		chk(sfo, 0);
		chk(ret, 0);
		@(posedge clk);
		rst <= 1'b0;
		rdc(A_GAIN, 32'h64);
		rdc(A_OFFSET, 0);
		repeat (6) @(posedge clk);
		#1 chk(sc, 1000);
		chk(sfo, 10'h0f0);
		print_verdict;
	end
endmodule // tb
bind ags_analog_scaler ags_checker #(.ADC_W(ADC_W), .FS_CODE(FS_CODE)) chk_u (.CLK_SYS_I,
	.SYS_RST_I, .ANALOG_VOLTAGE_INPUT_I, .SFB_IN_I, .POWER_FAIL_I, .REG_ADDR_I, .REG_RD_I,
	.REG_RDATA_O, .SFB_IN_O, .SFB_RETAIN_O, .SFB_RESTART_O);
